// file: hdl/qdac_fifo.sv
// Small valid/ready FIFO with registered read data.
`timescale 1ns/1ps
`default_nettype none
module qdac_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // The output register counts as one slot so full stays honest.
  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign push       = in_valid_i && in_ready_o;
  assign pop        = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      count_reg   <= '0;
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
      if (count_reg != '0 && (!out_valid_o || pop) &&
          !(out_valid_o && count_reg == (AW+1)'(1))) begin
        out_data_o  <= mem_reg[rd_ptr_reg];
        out_valid_o <= 1'b1;
        rd_ptr_reg  <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end else if (pop) begin
        out_valid_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/qdac_load_ctrl.sv
// Serial load control of a quad 12-bit converter with double buffering.
`timescale 1ns/1ps
`default_nettype none
module qdac_load_ctrl (
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        CHIP_SELECT_N_I,
  input  wire logic        SERIAL_CLK_I,
  input  wire logic        SERIAL_IN_I,
  input  wire logic        INPUT_LATCH_STROBE_N_I,
  input  wire logic        OUTPUT_LATCH_STROBE_N_I,
  input  wire logic        RESET_CODE_SELECT_I,
  output logic      [11:0] CODE_A_O,
  output logic      [11:0] CODE_B_O,
  output logic      [11:0] CODE_C_O,
  output logic      [11:0] CODE_D_O,
  output logic      [15:0] SHIFT_WORD_O
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Every pin but the reset passes two flops; only the second stage is used.
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic       sclk_s;
  logic       cs_n_s;
  logic       sdi_s;
  logic       ild_n_s;
  logic       old_n_s;
  logic       rsel_s;

  // The synchronisers run through reset, so the reset code select is
  // already settled when the registers take the reset code.
  always_ff @(posedge CLK_I) begin
    sync1_reg <= {RESET_CODE_SELECT_I, OUTPUT_LATCH_STROBE_N_I,
                  INPUT_LATCH_STROBE_N_I, SERIAL_IN_I,
                  CHIP_SELECT_N_I, SERIAL_CLK_I};
    sync2_reg <= sync1_reg;
  end

  assign sclk_s  = sync2_reg[0];
  assign cs_n_s  = sync2_reg[1];
  assign sdi_s   = sync2_reg[2];
  assign ild_n_s = sync2_reg[3];
  assign old_n_s = sync2_reg[4];
  assign rsel_s  = sync2_reg[5];

  // ****************************************************************
  // Shift clock edge detection
  // ****************************************************************
  logic gated_clk;
  logic gated_clk_reg;
  logic shift_edge;

  // The two pins are interchangeable; a late chip select rise while the
  // clock is low therefore also shifts one extra bit.
  assign gated_clk  = cs_n_s | sclk_s;
  assign shift_edge = gated_clk && !gated_clk_reg;

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      gated_clk_reg <= 1'b1;
    end else begin
      gated_clk_reg <= gated_clk;
    end
  end

  // ****************************************************************
  // Shift register
  // ****************************************************************
  // The system reset, which is also the device reset, clears it to SHIFT_RST.
  logic [15:0] shift_reg;

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      shift_reg <= qdac_pkg::SHIFT_RST;
    end else if (shift_edge) begin
      shift_reg <= {shift_reg[14:0], sdi_s};
    end
  end

  // ****************************************************************
  // Load word through the FIFO
  // ****************************************************************
  // While the input strobe is low the shifter contents stream into the
  // FIFO each time they change, so the addressed register follows the
  // bits as they flow, just as a transparent latch would.
  function automatic qdac_pkg::load_word_t decode_word(
    input logic [15:0] w
  );
    qdac_pkg::load_word_t r;
    r.channel = {w[qdac_pkg::ADDR_HI_POS], w[qdac_pkg::ADDR_LO_POS]};
    r.code    = w[qdac_pkg::CODE_W-1:0];
    return r;
  endfunction

  logic [15:0]          last_sent_reg;
  logic                 sent_valid_reg;
  logic                 want_push;
  logic                 fifo_in_ready;
  qdac_pkg::load_word_t fifo_out;
  logic                 fifo_out_valid;
  logic [11:0]          reset_code;
  logic [11:0]          rst_code_reg;

  assign reset_code = rsel_s ? qdac_pkg::CODE_MID
                             : qdac_pkg::CODE_ZERO;

  // Push when the strobe is low and the word differs from the last pushed.
  assign want_push = !ild_n_s &&
                     (!sent_valid_reg || last_sent_reg != shift_reg);

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      last_sent_reg  <= qdac_pkg::SHIFT_RST;
      sent_valid_reg <= 1'b0;
    end else begin
      if (ild_n_s) begin
        sent_valid_reg <= 1'b0;
      end else if (want_push && fifo_in_ready) begin
        last_sent_reg  <= shift_reg;
        sent_valid_reg <= 1'b1;
      end
    end
  end

  qdac_fifo #(
    .WIDTH ($bits(qdac_pkg::load_word_t)),
    .DEPTH (qdac_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .rstn_i      (RSTN_I),
    .in_data_i   (decode_word(shift_reg)),
    .in_valid_i  (want_push),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (1'b1)
  );

  // ****************************************************************
  // Input registers and converter registers
  // ****************************************************************
  logic [11:0] in_reg  [qdac_pkg::NUM_CH];
  logic [11:0] out_reg [qdac_pkg::NUM_CH];

  genvar ch;
  generate
    for (ch = 0; ch < qdac_pkg::NUM_CH; ch++) begin : g_ch
      always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
          in_reg[ch] <= rst_code_reg;
        end else if (fifo_out_valid &&
                     fifo_out.channel == 2'(ch)) begin
          in_reg[ch] <= fifo_out.code;
        end
      end

      // Transparent while the output strobe is low, holds when high.
      always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
          out_reg[ch] <= rst_code_reg;
        end else if (!old_n_s) begin
          out_reg[ch] <= in_reg[ch];
        end
      end
    end
  endgenerate

  // The system reset doubles as the device reset; its code follows the
  // select pin, and after release every input and converter register holds it until loaded.
  always_ff @(posedge CLK_I) begin
    rst_code_reg <= reset_code;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      CODE_A_O     <= rst_code_reg;
      CODE_B_O     <= rst_code_reg;
      CODE_C_O     <= rst_code_reg;
      CODE_D_O     <= rst_code_reg;
      SHIFT_WORD_O <= qdac_pkg::SHIFT_RST;
    end else begin
      CODE_A_O     <= out_reg[0];
      CODE_B_O     <= out_reg[1];
      CODE_C_O     <= out_reg[2];
      CODE_D_O     <= out_reg[3];
      SHIFT_WORD_O <= shift_reg;
    end
  end
endmodule
`default_nettype wire

// file: pkg/qdac_pkg.sv
// Constants and carrier types for the quad converter serial load control.
// Behaviour
// - Converter registers follow input registers while output strobe low, hold when high.
// - Addressed input register follows shift register while input strobe low, else holds.
// - Reset low forces all input and converter registers to the reset code.
// - Reset code is 000 hex with select low, 800 hex with select high.
// - Word is 16 bits: 2-bit channel address, two unused bits, 12-bit code.
// - Address 00 selects A, 01 B, 10 C, 11 D; high bit comes first.
// - Input strobe high selects no input register; all input registers stay latched.
// - After reset release, latched registers keep the reset code until loaded.
// - Shift register captures serial data on rising serial clock with select low.
// - Chip select OR serial clock; any rising edge of the OR shifts.
// - Address bits first, then unused bits, then code, most significant first.
// - Code is unsigned straight binary, zero is low reference.
// - Chip select rising while clock low shifts one extra bit.
package qdac_pkg;
  localparam int          WORD_W      = 16;
  localparam int          CODE_W      = 12;
  localparam int          NUM_CH      = 4;
  localparam int          ADDR_HI_POS = 15;
  localparam int          ADDR_LO_POS = 14;
  localparam logic [11:0] CODE_ZERO   = 12'h000;
  localparam logic [11:0] CODE_MID    = 12'h800;
  localparam logic [15:0] SHIFT_RST   = 16'h0000;
  localparam int          FIFO_DEPTH  = 4;
  localparam int          CLK_MHZ     = 10;

  // One decoded load word travelling from the shifter to the latches.
  typedef struct packed {
    logic [1:0]  channel;
    logic [11:0] code;
  } load_word_t;
endpackage

// file: testbench/qdac_host.sv
// Host model that clocks words into the serial pins.
`timescale 1ns/1ps
`default_nettype none
module qdac_host (
  input  wire logic clk_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);
  // ****
  // Frame driver
  // ****
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    sdi_o  = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Mode 1 lets select rise with the clock low; mode 2 clocks on select.
  task automatic send(input logic [15:0] w, input int mode);
    cs_n_o = 1'b0;
    if (mode == 2) sclk_o = 1'b0;
    hold(4);
    for (int i = 15; i >= 0; i--) begin
      sdi_o = w[i];
      if (mode == 2) cs_n_o = 1'b0;
      else sclk_o = 1'b0;
      hold(4);
      if (mode == 2) cs_n_o = 1'b1;
      else sclk_o = 1'b1;
      hold(4);
    end
    if (mode == 1) begin
      sclk_o = 1'b0;
      sdi_o  = ~w[0];
      hold(4);
    end
    cs_n_o = 1'b1;
    hold(4);
    sclk_o = 1'b1;
    // A released data line must not keep showing the last bit.
    sdi_o  = ~sdi_o;
  endtask
endmodule
`default_nettype wire

// file: testbench/qdac_load_ctrl_properties.sv
// Port-level checks of the converter load control.
`timescale 1ns/1ps
`default_nettype none
module qdac_load_ctrl_properties (
  input wire logic        CLK_I,
  input wire logic        RSTN_I,
  input wire logic        CHIP_SELECT_N_I,
  input wire logic        SERIAL_CLK_I,
  input wire logic        INPUT_LATCH_STROBE_N_I,
  input wire logic        OUTPUT_LATCH_STROBE_N_I,
  input wire logic        RESET_CODE_SELECT_I,
  input wire logic [11:0] CODE_A_O,
  input wire logic [11:0] CODE_B_O,
  input wire logic [11:0] CODE_C_O,
  input wire logic [11:0] CODE_D_O,
  input wire logic [15:0] SHIFT_WORD_O
);
  // ****
  // Properties
  // ****
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  wire        out_n = OUTPUT_LATCH_STROBE_N_I;
  wire        in_n  = INPUT_LATCH_STROBE_N_I;
  wire        link  = CHIP_SELECT_N_I | SERIAL_CLK_I;
  wire [47:0] codes = {CODE_A_O, CODE_B_O, CODE_C_O, CODE_D_O};
  // Sixteen cycles clear the pin synchronisers and the output pipeline.
  sequence out_shut;
    out_n[*8] ##1 out_n[*8];
  endsequence
  sequence out_open;
    (!out_n)[*8] ##1 (!out_n)[*8];
  endsequence
  sequence in_shut;
    (in_n && !out_n)[*8] ##1 (in_n && !out_n)[*8];
  endsequence
  chk_shift_hold:
    assert property (link[*7] |=> $stable(SHIFT_WORD_O))
    else $error("shift word moved while the link was quiet");
  chk_out_hold:
    assert property (out_shut |=> $stable(codes))
    else $error("converter code moved while latched");
  chk_in_hold:
    assert property (in_shut |=> $stable(codes))
    else $error("code moved with input strobe high");
  chk_reset_code:
    assert property ($rose(RSTN_I) |-> CODE_A_O == (RESET_CODE_SELECT_I ?
      qdac_pkg::CODE_MID : qdac_pkg::CODE_ZERO))
    else $error("wrong code after reset");
  chk_reset_all:
    assert property ($rose(RSTN_I) |-> codes == {4{CODE_A_O}})
    else $error("channels differ after reset");
  chk_load_a:
    assert property (out_open ##1 $changed(CODE_A_O) |->
      SHIFT_WORD_O[15:14] == 2'b00 && CODE_A_O == SHIFT_WORD_O[11:0])
    else $error("channel A loaded from a wrong word");
  chk_load_b:
    assert property (out_open ##1 $changed(CODE_B_O) |->
      SHIFT_WORD_O[15:14] == 2'b01)
    else $error("channel B loaded under a wrong address");
  chk_load_d:
    assert property (out_open ##1 $changed(CODE_D_O) |->
      SHIFT_WORD_O[15:14] == 2'b11 && CODE_D_O == SHIFT_WORD_O[11:0])
    else $error("channel D loaded from a wrong word");
endmodule
bind qdac_load_ctrl qdac_load_ctrl_properties chk (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .CHIP_SELECT_N_I(CHIP_SELECT_N_I),
  .SERIAL_CLK_I(SERIAL_CLK_I), .INPUT_LATCH_STROBE_N_I(INPUT_LATCH_STROBE_N_I),
  .OUTPUT_LATCH_STROBE_N_I(OUTPUT_LATCH_STROBE_N_I),
  .RESET_CODE_SELECT_I(RESET_CODE_SELECT_I), .CODE_A_O(CODE_A_O),
  .CODE_B_O(CODE_B_O), .CODE_C_O(CODE_C_O), .CODE_D_O(CODE_D_O),
  .SHIFT_WORD_O(SHIFT_WORD_O)
);
`default_nettype wire

// file: testbench/qdac_load_ctrl_test.sv
// Self-checking bench for the converter load control.
`timescale 1ns/1ps
`default_nettype none
module qdac_load_ctrl_test;
  // ****
  // Bench
  // ****
  logic             clk;
  logic             rstn;
  logic             ld_in_n;
  logic             ld_out_n;
  logic             sel;
  wire logic        cs_n;
  wire logic        sclk;
  wire logic        serial_in;
  wire logic [11:0] code [4];
  wire logic [15:0] shift;
  logic      [11:0] inp [4];
  logic      [11:0] conv [4];
  int               err_count = 0;
  int               n_checks = 0;
  qdac_host host (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(serial_in));
  qdac_load_ctrl uut (
    .CLK_I(clk), .RSTN_I(rstn), .CHIP_SELECT_N_I(cs_n),
    .SERIAL_CLK_I(sclk), .SERIAL_IN_I(serial_in),
    .INPUT_LATCH_STROBE_N_I(ld_in_n), .OUTPUT_LATCH_STROBE_N_I(ld_out_n),
    .RESET_CODE_SELECT_I(sel), .CODE_A_O(code[0]), .CODE_B_O(code[1]),
    .CODE_C_O(code[2]), .CODE_D_O(code[3]), .SHIFT_WORD_O(shift)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [11:0] rst_code(input logic s);
    return s ? qdac_pkg::CODE_MID : qdac_pkg::CODE_ZERO;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic check_all();
    for (int c = 0; c < 4; c++) check("code", {4'h0, code[c]}, {4'h0, conv[c]});
  endtask
  task automatic do_reset(input logic s, input int n);
    sel = s;
    @(negedge clk);
    rstn = 1'b0;
    repeat (n) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    for (int c = 0; c < 4; c++) inp[c] = rst_code(s);
    conv = inp;
    check_all();
  endtask
  task automatic load(input logic [1:0] ch, input logic [11:0] v, input int m);
    logic [15:0] w;
    w = {ch, 2'($urandom), v};
    host.send(w, m);
    repeat (8) @(negedge clk);
    if (m == 1) w = {w[14:0], ~w[0]};
    check("shift", shift, w);
    ld_in_n = 1'b0;
    repeat (4) @(negedge clk);
    ld_in_n = 1'b1;
    repeat (12) @(negedge clk);
    inp[w[15:14]] = w[11:0];
    if (!ld_out_n) conv[w[15:14]] = w[11:0];
    check_all();
  endtask
  task automatic pulse_out();
    ld_out_n = 1'b0;
    repeat (4) @(negedge clk);
    ld_out_n = 1'b1;
    repeat (12) @(negedge clk);
    conv = inp;
    check_all();
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // The whole sequence needs some 2500 cycles; the limit leaves a wide margin.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    logic [11:0] v;
    rstn = 1'b0;
    ld_in_n = 1'b1;
    ld_out_n = 1'b1;
    sel = 1'b1;
    void'($urandom(39687));
    do_reset(1'b1, 15);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom);
      load(2'(i), v, 0);
    end
    pulse_out();
    load(2'd0, 12'($urandom), 2);
    load(2'($urandom), 12'($urandom), 1);
    pulse_out();
    ld_out_n = 1'b0;
    repeat (16) @(negedge clk);
    conv = inp;
    for (int i = 0; i < 4; i++) load(2'(3 - i), 12'($urandom), 0);
    ld_out_n = 1'b1;
    repeat (16) @(negedge clk);
    do_reset(1'b0, 4);
    load(2'd1, 12'hfff, 0);
    pulse_out();
    final_report();
  end
endmodule
`default_nettype wire
